/* cstw_pkg.sv */
/*
 Shared constants, types and helper functions for the clock sources and
 tick counter block.
 Assumes a 125 MHz system clock; the oscillators themselves are modelled
 as sampled pin levels and tick strobes on that clock.
*/
package cstw_pkg;

	localparam int CLK_MHZ = 125;
	localparam int CLK_KHZ = CLK_MHZ * 1000;

	// main oscillator ranges: 3, 6, 12, 24, 48, 74 MHz
	localparam int MAIN_NUM_RANGES = 6;
	localparam logic [2:0] MAIN_SEL_RST = 3'h0;
	localparam logic [2:0] MAIN_SEL_LAST = 3'h5;
	localparam logic [16:0] MAIN_KHZ_R0 = 17'h00bb8;
	localparam logic [16:0] MAIN_KHZ_R1 = 17'h01770;
	localparam logic [16:0] MAIN_KHZ_R2 = 17'h02ee0;
	localparam logic [16:0] MAIN_KHZ_R3 = 17'h05dc0;
	localparam logic [16:0] MAIN_KHZ_R4 = 17'h0bb80;
	localparam logic [16:0] MAIN_KHZ_R5 = 17'h12110;
	localparam int TRIM_W_DEF = 8;

	typedef enum logic [1:0] {
		SRC_MAIN = 2'h0,
		SRC_XTAL = 2'h1,
		SRC_FABRIC = 2'h2
	} cstw_src_type;

	typedef enum logic [2:0] {
		PLL_OFF = 3'h1,
		PLL_WAIT = 3'h2,
		PLL_LOCKED = 3'h4
	} cstw_pll_state_type;

	localparam int PLL_LOCK_US = 250;
	// longest time: rounds down
	localparam int PLL_LOCK_CYCLES = (PLL_LOCK_US * CLK_MHZ) / 1;
	localparam int PLL_OUT_MIN_KHZ = 24000;
	localparam int PLL_OUT_MAX_KHZ = 80000;
	localparam int PLL_IN_OFFSET = 1;
	localparam int PLL_FB_OFFSET = 2;
	localparam logic [5:0] PLL_FB_CODE_BAD = 6'h3f;

	localparam int DBL_IN_MIN_MHZ = 6;
	localparam int DBL_IN_MAX_MHZ = 24;
	localparam int DBL_GAP_MIN = CLK_MHZ / (2 * DBL_IN_MAX_MHZ);
	localparam int DBL_GAP_MAX = (CLK_MHZ + 2 * DBL_IN_MIN_MHZ - 1) / (2 * DBL_IN_MIN_MHZ);

	localparam int LSO_SLOW_KHZ = 1;
	localparam int LSO_MID_KHZ = 33;
	localparam int LSO_FAST_KHZ = 100;

	localparam int TICK_W = 13;
	localparam int PER_SEL_W = 4;

	// half period in system cycles, rounded to nearest
	function automatic int half_cycles(input int f_khz);
		return (CLK_KHZ + f_khz) / (2 * f_khz);
	endfunction

	function automatic logic [16:0] main_khz(input logic [2:0] sel);
		case (sel)
			3'h0: return MAIN_KHZ_R0;
			3'h1: return MAIN_KHZ_R1;
			3'h2: return MAIN_KHZ_R2;
			3'h3: return MAIN_KHZ_R3;
			3'h4: return MAIN_KHZ_R4;
			default: return MAIN_KHZ_R5;
		endcase
	endfunction

endpackage

/* cstw_div.sv */
/*
 Even clock divider producing a 50% duty level and a rising-edge strobe.
 Assumes run comes from logic on clk; while run is low the count and level hold and the strobe stays low.
*/
`timescale 1ns/1ns
module cstw_div #(
	parameter int HALF = 625
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	output logic div_clk,
	output logic div_tick
);
	localparam int CW = (HALF > 2) ? $clog2(HALF) : 1;
	localparam logic [CW-1:0] HALF_M1 = CW'(HALF - 1);

	logic [CW-1:0] cnt_ff;
	logic div_clk_ff;
	logic div_tick_ff;

	assign div_clk = div_clk_ff;
	assign div_tick = div_tick_ff;

	// equal halves give an exact 50% duty
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_ff <= '0;
			div_clk_ff <= 1'b0;
			div_tick_ff <= 1'b0;
		end
		else if (run)
		begin
			div_tick_ff <= 1'b0;
			if (cnt_ff == HALF_M1)
			begin
				cnt_ff <= '0;
				div_clk_ff <= ~div_clk_ff;
				div_tick_ff <= ~div_clk_ff;
			end
			else
				cnt_ff <= cnt_ff + 1'b1;
		end
		else
			div_tick_ff <= 1'b0;
	end

	a_div_hold: assert property (@(posedge clk) disable iff (rst)
		!run |=> $stable(div_clk_ff) && !div_tick_ff)
		else $error("divider moved while stopped");
	a_div_edge: assert property (@(posedge clk) disable iff (rst)
		$changed(div_clk_ff) |-> $past(cnt_ff) == HALF_M1 && cnt_ff == '0)
		else $error("divider toggled off its half period");

endmodule

/* cstw_tick.sv */
/*
 13-bit free-running tick counter with periodic event and wakeup request.
 Assumes tick is a one-cycle strobe at 1 kHz and all inputs are on clk.
*/
`timescale 1ns/1ns
module cstw_tick (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic run,
	input wire logic clear,
	input wire logic [cstw_pkg::PER_SEL_W-1:0] per_sel,
	input wire logic wake_en,
	input wire logic wake_ack,
	output logic [cstw_pkg::TICK_W-1:0] count,
	output logic per_evt,
	output logic wake_req
);
	logic [cstw_pkg::TICK_W-1:0] count_ff;
	logic [cstw_pkg::TICK_W-1:0] nxt_count;
	logic per_evt_ff;
	logic wake_req_ff;
	logic adv;
	logic per_hit;

	assign count = count_ff;
	assign per_evt = per_evt_ff;
	assign wake_req = wake_req_ff;
	assign adv = tick && run && !clear;
	assign nxt_count = count_ff + 1'b1;
	// event when the chosen bit falls; per_sel above 12 picks the top bit
	assign per_hit = (per_sel >= cstw_pkg::PER_SEL_W'(cstw_pkg::TICK_W)) ?
		(count_ff[cstw_pkg::TICK_W-1] && !nxt_count[cstw_pkg::TICK_W-1]) :
		(count_ff[per_sel] && !nxt_count[per_sel]);

	always_ff @(posedge clk)
	begin
		if (rst || clear)
			count_ff <= '0;
		else if (adv)
			count_ff <= nxt_count;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			per_evt_ff <= 1'b0;
		else
			per_evt_ff <= adv && per_hit;
	end

	// set wins over acknowledge
	always_ff @(posedge clk)
	begin
		if (rst)
			wake_req_ff <= 1'b0;
		else if (adv && per_hit && wake_en)
			wake_req_ff <= 1'b1;
		else if (wake_ack)
			wake_req_ff <= 1'b0;
	end

	a_tick_advance: assert property (@(posedge clk) disable iff (rst)
		tick && run && !clear |=> count_ff == $past(count_ff) + 13'h0001)
		else $error("tick counter did not advance by one");
	a_tick_clear: assert property (@(posedge clk) disable iff (rst)
		clear |=> count_ff == '0)
		else $error("tick counter not cleared");
	a_tick_frozen: assert property (@(posedge clk) disable iff (rst)
		!run && !clear |=> $stable(count_ff))
		else $error("tick counter moved while stopped");
	a_tick_wrap: assert property (@(posedge clk) disable iff (rst)
		adv && count_ff == 13'h1fff |=> count_ff == 13'h0000 && per_evt_ff)
		else $error("tick counter wrap lost");
	a_wake_set: assert property (@(posedge clk) disable iff (rst)
		adv && per_hit && wake_en |=> wake_req_ff)
		else $error("wakeup request lost");

	c_tick_wrap: cover property (@(posedge clk) disable iff (rst)
		adv && count_ff == 13'h1fff);
	c_wake: cover property (@(posedge clk) disable iff (rst) $rose(wake_req_ff));

endmodule

/* cstw_top.sv */
/*
 Clock sources and tick counter: main oscillator range and trim, clock
 doubler, PLL lock supervision, low-speed clock dividers, tick counter.
 Assumes oscillator and fabric clocks arrive as pins sampled on clk;
 control inputs come from logic on clk.
*/
// Functional notes
// - direct routes may be any duty; divided outputs have exact 50% duty
// - main oscillator selects only 3, 6, 12, 24, 48 or 74 MHz
// - one stored trim per main range; the selected range's trim is applied
// - doubler output runs at exactly twice its input frequency
// - doubler input from main, crystal or fabric; valid 6 to 24 MHz
// - PLL input and feedback dividers give 4032 ratios; output 24 to 80 MHz
// - PLL reference from main oscillator, crystal or fabric
// - PLL locks within 250 us of enable and sets a readable lock bit
// - lock indication is a routable signal usable for an interrupt
// - low-speed oscillator gives 1 kHz, 33 kHz and 100 kHz clocks
// - tick counter is a 13-bit up counter stepped by the 1 kHz clock
// - tick counter runs except in hibernate and during debug halt
// - tick counter raises periodic events and wakeup requests
// - firmware write clears the tick counter, which then resumes
// - hibernate stops every clock and drops PLL lock but keeps the other register state
`timescale 1ns/1ns
module cstw_top #(
	parameter int TRIM_W = cstw_pkg::TRIM_W_DEF,
	parameter int PLL_LOCK_CYCLES = cstw_pkg::PLL_LOCK_CYCLES,
	parameter int LSO_SLOW_HALF = cstw_pkg::half_cycles(cstw_pkg::LSO_SLOW_KHZ),
	parameter int LSO_MID_HALF = cstw_pkg::half_cycles(cstw_pkg::LSO_MID_KHZ),
	parameter int LSO_FAST_HALF = cstw_pkg::half_cycles(cstw_pkg::LSO_FAST_KHZ),
	parameter logic [16:0] XTAL_KHZ = 17'h05dc0,
	parameter logic [16:0] FABRIC_KHZ = 17'h05dc0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic main_osc_clk,
	input wire logic mhz_crystal_osc,
	input wire logic fabric_clk,
	input wire logic hibernate,
	input wire logic debug_halt,
	input wire logic main_sel_wr,
	input wire logic [2:0] main_sel_code,
	input wire logic trim_wr,
	input wire logic [2:0] trim_idx,
	input wire logic [TRIM_W-1:0] trim_data,
	input wire logic dbl_en,
	input wire logic [1:0] dbl_src,
	input wire logic pll_en,
	input wire logic [1:0] pll_src,
	input wire logic [5:0] pll_in_code,
	input wire logic [5:0] pll_fb_code,
	input wire logic pll_use,
	input wire logic tick_clear,
	input wire logic [cstw_pkg::PER_SEL_W-1:0] per_sel,
	input wire logic wake_en,
	input wire logic wake_ack,
	output logic [2:0] main_sel,
	output logic [TRIM_W-1:0] main_trim,
	output logic dbl_tick,
	output logic dbl_range_ok,
	output logic pll_cfg_ok,
	output logic pll_lock,
	output logic pll_lock_evt,
	output logic sys_on_pll,
	output logic low_speed_oscillator_1k,
	output logic low_speed_oscillator_33k,
	output logic low_speed_oscillator_100k,
	output logic one_khz_tick_clock,
	output logic [cstw_pkg::TICK_W-1:0] central_tick_counter,
	output logic tick_evt,
	output logic wake_req
);
	localparam logic [TRIM_W-1:0] TRIM_RST = TRIM_W'(1) << (TRIM_W - 1);
	localparam logic [3:0] DBL_GAP_LO = 4'(cstw_pkg::DBL_GAP_MIN - 1);
	localparam logic [3:0] DBL_GAP_HI = 4'(cstw_pkg::DBL_GAP_MAX - 1);
	localparam int LCW = $clog2(PLL_LOCK_CYCLES + 1);
	// two cycles go to the enable edge and the state change
	localparam logic [LCW-1:0] LOCK_LAST = LCW'(PLL_LOCK_CYCLES - 2);
	localparam logic [31:0] OUT_MIN = 32'(cstw_pkg::PLL_OUT_MIN_KHZ);
	localparam logic [31:0] OUT_MAX = 32'(cstw_pkg::PLL_OUT_MAX_KHZ);

	function automatic logic [1:0] src_index(input logic [1:0] src);
		return (src == cstw_pkg::SRC_FABRIC || src == cstw_pkg::SRC_XTAL) ?
			src : cstw_pkg::SRC_MAIN;
	endfunction

	logic [2:0] src_meta_ff;
	logic [2:0] src_sync_ff;
	logic [2:0] src_prev_ff;
	logic [2:0] main_sel_ff;
	logic [TRIM_W-1:0] trim_mem [cstw_pkg::MAIN_NUM_RANGES];
	logic [TRIM_W-1:0] main_trim_ff;
	logic [3:0] gap_ff;
	logic dbl_tick_ff;
	logic dbl_range_ok_ff;
	logic dbl_edge;
	logic [16:0] ref_khz;
	logic [31:0] ref_prod;
	logic [31:0] in_ratio;
	logic cfg_ok;
	logic pll_cfg_ok_ff;
	cstw_pkg::cstw_pll_state_type pll_state_ff;
	cstw_pkg::cstw_pll_state_type nxt_pll_state;
	logic [LCW-1:0] lock_cnt_ff;
	logic pll_lock_ff;
	logic pll_lock_evt_ff;
	logic sys_on_pll_ff;
	logic pll_run;
	logic lso_run;
	logic tick_run;
	logic slow_tick;

	assign main_sel = main_sel_ff;
	assign main_trim = main_trim_ff;
	assign dbl_tick = dbl_tick_ff;
	assign dbl_range_ok = dbl_range_ok_ff;
	assign pll_cfg_ok = pll_cfg_ok_ff;
	assign pll_lock = pll_lock_ff;
	assign pll_lock_evt = pll_lock_evt_ff;
	assign sys_on_pll = sys_on_pll_ff;
	assign one_khz_tick_clock = low_speed_oscillator_1k;

	assign lso_run = !hibernate;
	assign tick_run = !hibernate && !debug_halt;
	assign pll_run = pll_en && !hibernate;

	// pin levels; the second and third stages are read, never the first
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			src_meta_ff <= 3'h0;
			src_sync_ff <= 3'h0;
			src_prev_ff <= 3'h0;
		end
		else
		begin
			src_meta_ff <= {fabric_clk, mhz_crystal_osc, main_osc_clk};
			src_sync_ff <= src_meta_ff;
			src_prev_ff <= src_sync_ff;
		end
	end

	// undefined range codes are ignored, keeping the last legal range
	always_ff @(posedge clk)
	begin
		if (rst)
			main_sel_ff <= cstw_pkg::MAIN_SEL_RST;
		else if (main_sel_wr && main_sel_code <= cstw_pkg::MAIN_SEL_LAST)
			main_sel_ff <= main_sel_code;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < cstw_pkg::MAIN_NUM_RANGES; i++)
				trim_mem[i] <= TRIM_RST;
		end
		else if (trim_wr && trim_idx <= cstw_pkg::MAIN_SEL_LAST)
			trim_mem[trim_idx] <= trim_data;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			main_trim_ff <= TRIM_RST;
		else
			main_trim_ff <= trim_mem[main_sel_ff];
	end

	// both edges of the chosen input give one strobe each
	assign dbl_edge = src_sync_ff[src_index(dbl_src)] ^ src_prev_ff[src_index(dbl_src)];

	always_ff @(posedge clk)
	begin
		if (rst)
			dbl_tick_ff <= 1'b0;
		else
			dbl_tick_ff <= dbl_en && lso_run && dbl_edge;
	end

	// half-period check; a sampled input cannot be judged finer than a cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gap_ff <= 4'hf;
			dbl_range_ok_ff <= 1'b0;
		end
		else if (dbl_edge)
		begin
			gap_ff <= 4'h0;
			dbl_range_ok_ff <= gap_ff >= DBL_GAP_LO && gap_ff <= DBL_GAP_HI;
		end
		else if (gap_ff != 4'hf)
			gap_ff <= gap_ff + 4'h1;
		else
			dbl_range_ok_ff <= 1'b0;
	end

	always_comb
	begin
		case (src_index(pll_src))
			cstw_pkg::SRC_XTAL: ref_khz = XTAL_KHZ;
			cstw_pkg::SRC_FABRIC: ref_khz = FABRIC_KHZ;
			default: ref_khz = cstw_pkg::main_khz(main_sel_ff);
		endcase
	end

	// 64 input divides times 63 feedback multiplies
	assign in_ratio = 32'(pll_in_code) + 32'(cstw_pkg::PLL_IN_OFFSET);
	assign ref_prod = 32'(ref_khz) * (32'(pll_fb_code) + 32'(cstw_pkg::PLL_FB_OFFSET));
	assign cfg_ok = pll_fb_code != cstw_pkg::PLL_FB_CODE_BAD &&
		ref_prod >= OUT_MIN * in_ratio && ref_prod <= OUT_MAX * in_ratio;

	always_ff @(posedge clk)
	begin
		if (rst)
			pll_cfg_ok_ff <= 1'b0;
		else
			pll_cfg_ok_ff <= cfg_ok;
	end

	always_comb
	begin
		nxt_pll_state = pll_state_ff;
		case (pll_state_ff)
			cstw_pkg::PLL_OFF:
				if (pll_run)
					nxt_pll_state = cstw_pkg::PLL_WAIT;
			cstw_pkg::PLL_WAIT:
				if (!pll_run)
					nxt_pll_state = cstw_pkg::PLL_OFF;
				else if (pll_cfg_ok_ff && lock_cnt_ff == LOCK_LAST)
					nxt_pll_state = cstw_pkg::PLL_LOCKED;
			cstw_pkg::PLL_LOCKED:
				if (!pll_run)
					nxt_pll_state = cstw_pkg::PLL_OFF;
				else if (!pll_cfg_ok_ff)
					nxt_pll_state = cstw_pkg::PLL_WAIT;
			default:
				nxt_pll_state = cstw_pkg::PLL_OFF;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			pll_state_ff <= cstw_pkg::PLL_OFF;
		else
			pll_state_ff <= nxt_pll_state;
	end

	// an out-of-range setting keeps the loop from ever reporting lock
	always_ff @(posedge clk)
	begin
		if (rst)
			lock_cnt_ff <= '0;
		else if (pll_state_ff == cstw_pkg::PLL_WAIT && pll_cfg_ok_ff && lock_cnt_ff != LOCK_LAST)
			lock_cnt_ff <= lock_cnt_ff + 1'b1;
		else if (pll_state_ff != cstw_pkg::PLL_WAIT || !pll_cfg_ok_ff)
			lock_cnt_ff <= '0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pll_lock_ff <= 1'b0;
			pll_lock_evt_ff <= 1'b0;
		end
		else
		begin
			pll_lock_ff <= nxt_pll_state == cstw_pkg::PLL_LOCKED;
			pll_lock_evt_ff <= nxt_pll_state == cstw_pkg::PLL_LOCKED &&
				pll_state_ff != cstw_pkg::PLL_LOCKED;
		end
	end

	// consumer mux select drops in the same cycle as the lock bit
	always_ff @(posedge clk)
	begin
		if (rst)
			sys_on_pll_ff <= 1'b0;
		else
			sys_on_pll_ff <= pll_use && pll_lock_ff &&
				nxt_pll_state == cstw_pkg::PLL_LOCKED;
	end

	cstw_div #(.HALF(LSO_SLOW_HALF)) u_div_slow (
		.clk(clk),
		.rst(rst),
		.run(lso_run),
		.div_clk(low_speed_oscillator_1k),
		.div_tick(slow_tick)
	);

	cstw_div #(.HALF(LSO_MID_HALF)) u_div_mid (
		.clk(clk),
		.rst(rst),
		.run(lso_run),
		.div_clk(low_speed_oscillator_33k),
		.div_tick()
	);

	cstw_div #(.HALF(LSO_FAST_HALF)) u_div_fast (
		.clk(clk),
		.rst(rst),
		.run(lso_run),
		.div_clk(low_speed_oscillator_100k),
		.div_tick()
	);

	cstw_tick u_tick (
		.clk(clk),
		.rst(rst),
		.tick(slow_tick),
		.run(tick_run),
		.clear(tick_clear),
		.per_sel(per_sel),
		.wake_en(wake_en),
		.wake_ack(wake_ack),
		.count(central_tick_counter),
		.per_evt(tick_evt),
		.wake_req(wake_req)
	);

	// helper: cycles since the PLL was enabled with a valid setting
	logic [31:0] en_cnt_ff;
	always_ff @(posedge clk)
	begin
		if (rst || !pll_run || !pll_cfg_ok_ff)
			en_cnt_ff <= 32'h0;
		else if (en_cnt_ff != 32'hffffffff)
			en_cnt_ff <= en_cnt_ff + 32'h1;
	end

	a_lock_within: assert property (@(posedge clk) disable iff (rst)
		en_cnt_ff >= 32'(PLL_LOCK_CYCLES) |-> pll_lock_ff)
		else $error("pll lock later than allowed");
	a_lock_needs_en: assert property (@(posedge clk) disable iff (rst)
		(!pll_en || hibernate) |=> !pll_lock_ff)
		else $error("lock reported with pll stopped");
	a_sys_on_ref: assert property (@(posedge clk) disable iff (rst)
		!pll_lock_ff |-> !sys_on_pll_ff)
		else $error("consumers on pll before lock");
	a_lock_event: assert property (@(posedge clk) disable iff (rst)
		$rose(pll_lock_ff) |-> pll_lock_evt_ff ##1 !pll_lock_evt_ff)
		else $error("lock event missing or stretched");
	a_dbl_strobe: assert property (@(posedge clk) disable iff (rst)
		dbl_en && !hibernate && dbl_edge |=> dbl_tick_ff)
		else $error("doubler missed an input edge");
	a_sel_legal: assert property (@(posedge clk) disable iff (rst)
		main_sel_wr && main_sel_code > 3'h5 |=> $stable(main_sel_ff) && main_sel_ff <= 3'h5)
		else $error("illegal main range accepted");
	a_trim_apply: assert property (@(posedge clk) disable iff (rst)
		trim_wr && trim_idx == main_sel_ff && trim_idx <= 3'h5 && !main_sel_wr
		|=> ##1 main_trim_ff == $past(trim_data, 2))
		else $error("selected range trim not applied");
	a_cfg_range: assert property (@(posedge clk) disable iff (rst)
		pll_lock_ff |-> $past(pll_cfg_ok_ff))
		else $error("lock with out-of-range pll setting");

	c_pll_lock: cover property (@(posedge clk) disable iff (rst) $rose(pll_lock_ff));
	c_dbl_ok: cover property (@(posedge clk) disable iff (rst) $rose(dbl_range_ok_ff));
	c_tick_evt: cover property (@(posedge clk) disable iff (rst) tick_evt);

endmodule

/* cstw_osc_model.sv */
/*
 Behavioural oscillator pins feeding the clock block: main, crystal, fabric.
 Assumes half periods in clk cycles come from the bench; zero parks a pin.
*/
`timescale 1ns/1ns
module cstw_osc_model (
	input wire logic clk,
	input wire logic [7:0] half_main,
	input wire logic [7:0] half_xtal,
	input wire logic [7:0] half_fab,
	output logic main_pin,
	output logic xtal_pin,
	output logic fab_pin
);
	logic [7:0] cnt_ff [3] = '{8'h00, 8'h00, 8'h00};
	logic [2:0] lvl_ff = 3'h0;
	logic [7:0] half [3];

	assign half[0] = half_main;
	assign half[1] = half_xtal;
	assign half[2] = half_fab;
	assign main_pin = lvl_ff[0];
	assign xtal_pin = lvl_ff[1];
	assign fab_pin = lvl_ff[2];

	always @(posedge clk)
	begin
		for (int i = 0; i < 3; i++)
		begin
			// a stopped oscillator holds its level, it does not float
			if (half[i] == 8'h00)
				cnt_ff[i] <= 8'h00;
			else if (cnt_ff[i] + 8'h01 >= half[i])
			begin
				cnt_ff[i] <= 8'h00;
				lvl_ff[i] <= ~lvl_ff[i];
			end
			else
				cnt_ff[i] <= cnt_ff[i] + 8'h01;
		end
	end
endmodule

/* cstw_tb.sv */
/*
 Self-checking bench for the clock sources and tick counter block.
 Assumes shortened lock and low-speed half periods; oscillators from the model.
*/
`timescale 1ns/1ns
module tb;
	localparam int LOCK = 40;
	localparam int SLOW = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hibernate = 1'b0, debug_halt = 1'b0, main_sel_wr = 1'b0, trim_wr = 1'b0;
	logic [2:0] main_sel_code = 3'h0, trim_idx = 3'h0;
	logic [7:0] trim_data = 8'h00;
	logic dbl_en = 1'b0, pll_en = 1'b0, pll_use = 1'b0, tick_clear = 1'b0;
	logic [1:0] dbl_src = 2'h0, pll_src = 2'h0;
	logic [5:0] pll_in_code = 6'h00, pll_fb_code = 6'h00;
	logic [3:0] per_sel = 4'h0;
	logic wake_en = 1'b0, wake_ack = 1'b0;
	logic [7:0] h_main = 8'h04, h_xtal = 8'h03, h_fab = 8'h06;
	logic main_pin, xtal_pin, fab_pin;
	logic [2:0] main_sel;
	logic [7:0] main_trim;
	logic dbl_tick, dbl_range_ok, pll_cfg_ok, pll_lock, pll_lock_evt, sys_on_pll;
	logic lso_1k, lso_33k, lso_100k, tick_clk, tick_evt, wake_req;
	logic [12:0] count;
	int n_mismatch = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	logic [12:0] c0;
	logic b0;
	// last entry is out of range: the enable that follows must not lock
	int t_src[8] = '{0, 0, 0, 0, 0, 1, 2, 1};
	int t_in[8] = '{0, 0, 0, 0, 0, 0, 1, 0};
	int t_fb[8] = '{5, 6, 24, 25, 63, 0, 0, 2};
	int t_ok[8] = '{0, 1, 1, 0, 0, 1, 1, 0};

	always #4 clk = ~clk;

	cstw_osc_model osc (.clk(clk), .half_main(h_main), .half_xtal(h_xtal), .half_fab(h_fab),
		.main_pin(main_pin), .xtal_pin(xtal_pin), .fab_pin(fab_pin));

	cstw_top #(.PLL_LOCK_CYCLES(LOCK), .LSO_SLOW_HALF(SLOW), .LSO_MID_HALF(5),
		.LSO_FAST_HALF(3)) DUT (
		.clk(clk), .rst(rst), .main_osc_clk(main_pin), .mhz_crystal_osc(xtal_pin),
		.fabric_clk(fab_pin), .hibernate(hibernate), .debug_halt(debug_halt),
		.main_sel_wr(main_sel_wr), .main_sel_code(main_sel_code), .trim_wr(trim_wr),
		.trim_idx(trim_idx), .trim_data(trim_data), .dbl_en(dbl_en), .dbl_src(dbl_src),
		.pll_en(pll_en), .pll_src(pll_src), .pll_in_code(pll_in_code),
		.pll_fb_code(pll_fb_code), .pll_use(pll_use), .tick_clear(tick_clear),
		.per_sel(per_sel), .wake_en(wake_en), .wake_ack(wake_ack), .main_sel(main_sel),
		.main_trim(main_trim), .dbl_tick(dbl_tick), .dbl_range_ok(dbl_range_ok),
		.pll_cfg_ok(pll_cfg_ok), .pll_lock(pll_lock), .pll_lock_evt(pll_lock_evt),
		.sys_on_pll(sys_on_pll), .low_speed_oscillator_1k(lso_1k),
		.low_speed_oscillator_33k(lso_33k), .low_speed_oscillator_100k(lso_100k),
		.one_khz_tick_clock(tick_clk), .central_tick_counter(count), .tick_evt(tick_evt),
		.wake_req(wake_req));

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// generous ceiling: the whole sequence needs well under 2000 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic settle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wr_range(input logic [2:0] code);
		@(posedge clk);
		main_sel_wr <= 1'b1;
		main_sel_code <= code;
		@(posedge clk);
		main_sel_wr <= 1'b0;
		settle(3);
	endtask

	task automatic wr_trim(input logic [2:0] idx, input logic [7:0] data);
		@(posedge clk);
		trim_wr <= 1'b1;
		trim_idx <= idx;
		trim_data <= data;
		@(posedge clk);
		trim_wr <= 1'b0;
	endtask

	task automatic count_ticks(input int k, output int c);
		c = 0;
		repeat (k)
		begin
			@(negedge clk);
			if (dbl_tick === 1'b1)
				c++;
		end
	endtask

	function automatic logic lso_pick(input int i);
		return i == 0 ? lso_100k : (i == 1 ? lso_33k : (i == 2 ? lso_1k : tick_clk));
	endfunction

	// high and low phases measured separately, so a skewed divider shows
	task automatic duty(input int i, input int half);
		int hi;
		int lo;
		hi = 0;
		lo = 0;
		n = 0;
		// a high phase already under way would be counted short
		while (lso_pick(i) === 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		while (!(lso_pick(i) === 1'b1) && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		while (lso_pick(i) === 1'b1 && hi < 100)
		begin
			@(negedge clk);
			hi++;
		end
		while (lso_pick(i) === 1'b0 && lo < 100)
		begin
			@(negedge clk);
			lo++;
		end
		chk("lso high cycles", half, hi);
		chk("lso low cycles", half, lo);
	endtask

	task automatic wait_evt();
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (tick_evt !== 1'b1 && n < 300);
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		settle(3);
		chk("main_sel reset", 3'h0, main_sel);
		chk("main_trim reset", 8'h80, main_trim);
		chk("pll_lock reset", 1'b0, pll_lock);
		for (int i = 0; i < 6; i++)
			wr_trim(3'(i), 8'(i * 17 + 3));
		for (int i = 0; i < 6; i++)
		begin
			wr_range(3'(i));
			chk("main_sel", i, main_sel);
			chk("main_trim", i * 17 + 3, main_trim);
		end
		wr_range(3'h6);
		chk("main_sel code 6", 3'h5, main_sel);
		wr_range(3'h7);
		chk("main_sel code 7", 3'h5, main_sel);
		wr_range(3'h0);
		wr_trim(3'h6, 8'hff);
		settle(3);
		chk("trim slot 6", 8'h03, main_trim);
		@(posedge clk) dbl_en <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			@(posedge clk) dbl_src <= 2'(s);
			settle(30);
			count_ticks(60, n);
			chk("doubler ticks", s == 1 ? 20 : (s == 2 ? 10 : 15), n);
			chk("doubler range", 1'b1, dbl_range_ok);
		end
		@(posedge clk);
		h_fab <= 8'h14;
		dbl_src <= 2'h2;
		settle(60);
		chk("doubler slow input", 1'b0, dbl_range_ok);
		@(posedge clk) dbl_en <= 1'b0;
		settle(10);
		count_ticks(40, n);
		chk("doubler off", 0, n);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			pll_src <= 2'(t_src[i]);
			pll_in_code <= 6'(t_in[i]);
			pll_fb_code <= 6'(t_fb[i]);
			settle(3);
			chk("pll_cfg_ok", t_ok[i], pll_cfg_ok);
		end
		@(posedge clk);
		pll_en <= 1'b1;
		settle(100);
		chk("bad cfg no lock", 1'b0, pll_lock);
		@(posedge clk);
		pll_src <= 2'h0;
		pll_in_code <= 6'h00;
		pll_fb_code <= 6'h0e;
		pll_en <= 1'b0;
		pll_use <= 1'b1;
		settle(4);
		@(posedge clk) pll_en <= 1'b1;
		n = 0;
		do
		begin
			settle(1);
			n++;
			if (n == LOCK)
				chk("sys_on_pll early", 1'b0, sys_on_pll);
		end
		while (pll_lock !== 1'b1 && n < 200);
		chk("lock cycles", LOCK, n);
		chk("lock event", 1'b1, pll_lock_evt);
		settle(1);
		chk("sys_on_pll", 1'b1, sys_on_pll);
		chk("lock event end", 1'b0, pll_lock_evt);
		chk("lock held", 1'b1, pll_lock);
		for (int i = 0; i < 4; i++)
			duty(i, i == 0 ? 3 : (i == 1 ? 5 : SLOW));
		chk("1k alias", lso_1k, tick_clk);
		@(posedge clk) tick_clear <= 1'b1;
		@(posedge clk) tick_clear <= 1'b0;
		#1;
		chk("clear", 13'h0000, count);
		c0 = count;
		settle(64);
		chk("count advance", c0 + 13'h0004, count);
		@(posedge clk) debug_halt <= 1'b1;
		settle(2);
		c0 = count;
		settle(48);
		chk("debug freeze", c0, count);
		@(posedge clk);
		debug_halt <= 1'b0;
		hibernate <= 1'b1;
		settle(3);
		c0 = count;
		b0 = lso_1k;
		chk("hibernate lock", 1'b0, pll_lock);
		settle(48);
		chk("hibernate count", c0, count);
		chk("hibernate lso", b0, lso_1k);
		@(posedge clk) hibernate <= 1'b0;
		settle(60);
		chk("relock", 1'b1, pll_lock);
		@(posedge clk) pll_en <= 1'b0;
		settle(2);
		chk("pll off", 1'b0, pll_lock);
		@(posedge clk);
		wake_en <= 1'b1;
		per_sel <= 4'h0;
		// an event on the enabling edge itself would not yet set the request
		settle(2);
		wait_evt();
		chk("bit0 fell", 1'b0, count[0]);
		chk("wake_req", 1'b1, wake_req);
		@(posedge clk) wake_ack <= 1'b1;
		@(posedge clk) wake_ack <= 1'b0;
		settle(1);
		chk("wake ack", 1'b0, wake_req);
		@(posedge clk);
		wake_en <= 1'b0;
		per_sel <= 4'h2;
		settle(2);
		wait_evt();
		chk("bit2 fell", 3'h0, count[2:0]);
		chk("wake disabled", 1'b0, wake_req);
		give_verdict();
	end
endmodule
